//--- logic/stream_match_defines.vh
// Register offsets, field positions and reset values for the stream-match table
`ifndef STREAM_MATCH_DEFINES_VH
`define STREAM_MATCH_DEFINES_VH

// ****************************************************************
// Register map (byte offsets)
// ****************************************************************
`define SMT_CTRL_OFS          12'h000
`define SMT_STATUS_OFS        12'h004
`define SMT_WIDE_VALID_OFS    12'h008
`define SMT_SEC_FLUSH_OFS     12'h00c
`define SMT_ENTRY_BASE        12'h400
`define SMT_ENTRY_LIMIT       12'h800

// ****************************************************************
// Control register fields
// ****************************************************************
`define SMT_CTRL_WIDE_BIT     0
`define SMT_CTRL_EXT_BIT      1
`define SMT_CTRL_RST          2'h0

// ****************************************************************
// Status register fields
// ****************************************************************
`define SMT_ST_HIT_BIT        31
`define SMT_ST_MULTI_BIT      30
`define SMT_ST_WIDTH_LSB      16
`define SMT_ST_IDX_LSB        0

// ****************************************************************
// Narrow layout fields
// ****************************************************************
`define SMT_N_VALID_BIT       31
`define SMT_N_MASK_LSB        16
`define SMT_N_RSVD_BIT        15
`define SMT_N_ID_LSB          0
`define SMT_N_FIELD_W         15

// ****************************************************************
// Wide layout fields
// ****************************************************************
`define SMT_W_MASK_LSB        16
`define SMT_W_ID_LSB          0
`define SMT_W_FIELD_W         16

// ****************************************************************
// Extended group aliasing
// ****************************************************************
`define SMT_EXT_ALIAS_COUNT   128

`endif

//--- logic/stream_match_table.v
// Stream-match table with Wishbone register port and secure flush-all command
`timescale 1ns/1ps
`include "stream_match_defines.vh"

module stream_match_table #(
  parameter NUM_ENTRIES  = 8,
  parameter IDX_W        = 3,
  parameter ID_BITS      = 15,
  parameter SID_MATCHING = 1,
  parameter TWO_SEC      = 1,
  parameter EXT_GROUPS   = 0
) (
  // Clock and reset
  input  wire                 i_clk,
  input  wire                 i_nrst,
  // Wishbone slave
  input  wire                 i_wb_cyc,
  input  wire                 i_wb_stb,
  input  wire                 i_wb_we,
  input  wire [11:0]          i_wb_adr,
  input  wire [3:0]           i_wb_sel,
  input  wire [31:0]          i_wb_dat,
  output reg  [31:0]          o_wb_dat,
  output reg                  o_wb_ack,
  // Lookup request
  input  wire                 i_sid_valid,
  input  wire [15:0]          i_sid,
  // Lookup result
  output reg                  o_lookup_done,
  output reg                  o_hit,
  output reg                  o_multi_hit,
  output reg  [7:0]           o_hit_idx,
  // TLB maintenance
  output reg                  o_sec_flush
);

  // ****************************************************************
  // Implemented bit masks
  // ****************************************************************
  localparam [14:0] NARROW_FIELD = (ID_BITS >= 15) ? 15'h7fff :
                                   ((15'h1 << ID_BITS) - 15'h1);
  // Narrow layout keeps ID_BITS identifier and mask bits, the wide layout all 16 of each
  localparam [31:0] NARROW_IMPL = {1'b1, NARROW_FIELD, 1'b0, NARROW_FIELD};
  localparam [31:0] WIDE_IMPL   = 32'hffff_ffff;

  // Implemented bits of an entry under the current layout
  function [31:0] impl_bits;
    input wide;
    begin
      impl_bits = wide ? WIDE_IMPL : NARROW_IMPL;
    end
  endfunction

  // Byte-enable merge of write data onto old contents
  function [31:0] merge_sel;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer b;
    begin
      merge_sel = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_sel[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [1:0]             ctrl_q;
  reg  [NUM_ENTRIES-1:0] wide_valid_q;
  reg  [NUM_ENTRIES-1:0] written_q;
  reg  [31:0]            entry_mem [0:NUM_ENTRIES-1];
  reg  [31:0]            last_status_q;

  // Paired valid bits merged byte-wise in a full word, then cut to the entry count
  wire [31:0] wval_new = merge_sel({{(32-NUM_ENTRIES){1'b0}}, wide_valid_q}, i_wb_dat,
                                   i_wb_sel);

  wire wide_en = ctrl_q[`SMT_CTRL_WIDE_BIT];
  wire ext_en  = ctrl_q[`SMT_CTRL_EXT_BIT] && (EXT_GROUPS >= `SMT_EXT_ALIAS_COUNT);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        req      = i_wb_cyc && i_wb_stb;
  wire        wr_take  = req && i_wb_we && o_wb_ack;
  wire        hit_ent  = (i_wb_adr >= `SMT_ENTRY_BASE) && (i_wb_adr < `SMT_ENTRY_LIMIT);
  wire [11:0] ent_ofs  = i_wb_adr - `SMT_ENTRY_BASE;
  wire [9:0]  ent_word = ent_ofs[11:2];
  wire        ent_ok   = hit_ent && (ent_word < NUM_ENTRIES) && (SID_MATCHING != 0);
  wire [IDX_W-1:0] ent_idx = ent_word[IDX_W-1:0];

  wire is_ctrl  = (i_wb_adr[11:2] == `SMT_CTRL_OFS >> 2);
  wire is_stat  = (i_wb_adr[11:2] == `SMT_STATUS_OFS >> 2);
  wire is_wval  = (i_wb_adr[11:2] == `SMT_WIDE_VALID_OFS >> 2);
  wire is_flush = (i_wb_adr[11:2] == `SMT_SEC_FLUSH_OFS >> 2);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (ent_ok) begin
      // Masked identifier bits are returned as stored
      rd_d = entry_mem[ent_idx] & impl_bits(wide_en);
    end else if (is_ctrl) begin
      rd_d = {30'h0000_0000, ctrl_q};
    end else if (is_stat) begin
      rd_d = last_status_q;
    end else if (is_wval) begin
      rd_d[NUM_ENTRIES-1:0] = wide_valid_q;
    end
    // Flush command is write only, always reads zero
  end

  // ****************************************************************
  // Wishbone answer: ack one cycle after the request is seen
  // ****************************************************************
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req && !o_wb_ack;
      o_wb_dat <= (req && !o_wb_ack && !i_wb_we) ? rd_d : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Control and paired valid bits
  // ****************************************************************
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q       <= `SMT_CTRL_RST;
      wide_valid_q <= {NUM_ENTRIES{1'b0}};
    end else if (wr_take) begin
      if (is_ctrl && i_wb_sel[0]) begin
        ctrl_q <= i_wb_dat[1:0];
      end
      if (is_wval) begin
        wide_valid_q <= wval_new[NUM_ENTRIES-1:0];
      end
    end
  end

  // ****************************************************************
  // Match entries: storage carries no reset
  // ****************************************************************
  // Software must program entries before use; until written, an entry
  // is kept out of the search so garbage cannot alias a real stream.
  always @(posedge i_clk) begin
    if (wr_take && ent_ok) begin
      entry_mem[ent_idx] <= merge_sel(entry_mem[ent_idx], i_wb_dat, i_wb_sel)
                            & impl_bits(wide_en);
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      written_q <= {NUM_ENTRIES{1'b0}};
    end else if (wr_take && ent_ok) begin
      written_q[ent_idx] <= 1'b1;
    end
  end

  // ****************************************************************
  // Secure flush-all command
  // ****************************************************************
  // Pulse goes to the TLB, which keeps locked lines and leaves the
  // secure hypervisor bank alone; that bank needs its own command.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sec_flush <= 1'b0;
    end else begin
      // Any value, any byte lanes; ignored without two security states
      o_sec_flush <= wr_take && is_flush && (TWO_SEC != 0);
    end
  end

  // ****************************************************************
  // Parallel compare, one comparator per entry
  // ****************************************************************
  wire [NUM_ENTRIES-1:0] match_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g = g + 1) begin : g_cmp
      wire [31:0] e      = entry_mem[g];
      wire [15:0] n_mask = {1'b0, e[30:16]};
      wire [15:0] n_id   = {1'b0, e[14:0]};
      wire [15:0] w_mask = e[31:16];
      wire [15:0] w_id   = e[15:0];
      wire        n_val  = e[`SMT_N_VALID_BIT];
      // Extended groups share the same paired valid array
      wire        w_val  = wide_valid_q[g];
      wire [15:0] msk    = wide_en ? w_mask : n_mask;
      wire [15:0] idv    = wide_en ? w_id : n_id;
      wire [15:0] sid    = wide_en ? i_sid : {1'b0, i_sid[14:0]};
      wire        vld    = written_q[g] && (wide_en ? w_val : n_val);
      assign match_vec[g] = vld && (((idv ^ sid) & ~msk) == 16'h0000);
    end
  endgenerate

  // ****************************************************************
  // Priority select and multi-match detect
  // ****************************************************************
  reg  [IDX_W-1:0] first_idx;
  reg              any_hit;
  reg              multi;
  integer          k;
  always @* begin
    first_idx = {IDX_W{1'b0}};
    any_hit   = 1'b0;
    multi     = 1'b0;
    for (k = NUM_ENTRIES - 1; k >= 0; k = k - 1) begin
      if (match_vec[k]) begin
        if (any_hit) begin
          multi = 1'b1;
        end
        any_hit   = 1'b1;
        first_idx = k[IDX_W-1:0];
      end
    end
  end

  // Aliased onto the top of the extended groups when enabled
  localparam integer EXT_BASE_I = EXT_GROUPS - `SMT_EXT_ALIAS_COUNT;
  wire [7:0] base_ofs = ext_en ? EXT_BASE_I[7:0] : 8'h00;
  wire [7:0] rep_idx  = base_ofs + {{(8-IDX_W){1'b0}}, first_idx};

  // ****************************************************************
  // Lookup result, one cycle after request
  // ****************************************************************
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lookup_done <= 1'b0;
      o_hit         <= 1'b0;
      o_multi_hit   <= 1'b0;
      o_hit_idx     <= 8'h00;
      last_status_q <= 32'h0000_0000;
    end else begin
      o_lookup_done <= i_sid_valid && (SID_MATCHING != 0);
      if (i_sid_valid && (SID_MATCHING != 0)) begin
        o_hit         <= any_hit;
        o_multi_hit   <= multi;
        o_hit_idx     <= any_hit ? rep_idx : 8'h00;
        last_status_q <= {any_hit, multi, 6'h00,
                          wide_en ? 8'h10 : ID_BITS[7:0],
                          8'h00, any_hit ? rep_idx : 8'h00};
      end
    end
  end

endmodule // stream_match_table

//--- tb/stream_match_table_monitor.sv
// Port checker for the stream-match table
`timescale 1ns/1ps
module stream_match_table_monitor (
  // Clock and reset
  input wire        i_clk,
  input wire        i_nrst,
  // Register port
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [11:0] i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  // Lookup and flush
  input wire        i_sid_valid,
  input wire        o_lookup_done,
  input wire        o_hit,
  input wire        o_multi_hit,
  input wire [7:0]  o_hit_idx,
  input wire        o_sec_flush
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire req = i_wb_cyc && i_wb_stb;
  wire cmd = req && o_wb_ack && i_wb_adr[11:2] == 10'h003;
  AST_ACK_ONE: assert property (req && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
  AST_DAT_IDLE:
    assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data off ack");
  AST_FLUSH_GO:
    assert property (cmd && i_wb_we |=> o_sec_flush) else $error("no flush");
  AST_FLUSH_WHY:
    assert property (o_sec_flush |-> $past(cmd && i_wb_we)) else $error("stray flush");
  AST_CMD_RAZ:
    assert property (cmd && !i_wb_we |-> o_wb_dat == 32'h0) else $error("cmd reads");
  AST_LOOKUP: assert property (i_sid_valid |=> o_lookup_done) else $error("no done");
  AST_DONE_WHY:
    assert property (o_lookup_done |-> $past(i_sid_valid)) else $error("stray done");
  AST_MULTI: assert property (o_multi_hit |-> o_hit) else $error("multi no hit");
  AST_IDX: assert property (!o_hit |-> o_hit_idx == 8'h00) else $error("idx on miss");
  AST_HOLD:
    assert property (!o_lookup_done |-> $stable({o_hit, o_multi_hit, o_hit_idx}))
      else $error("result moved");
endmodule // stream_match_table_monitor

//--- tb/tb.sv
// Self-checking bench for the stream-match table
`timescale 1ns/1ps
`include "stream_match_defines.vh"
module tb;
  reg          i_clk, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, i_sid_valid;
  reg  [11:0]  i_wb_adr;
  reg  [3:0]   i_wb_sel;
  reg  [31:0]  i_wb_dat;
  reg  [15:0]  i_sid;
  wire [31:0]  o_wb_dat;
  wire [7:0]   o_hit_idx;
  wire         o_wb_ack, o_lookup_done, o_hit, o_multi_hit, o_sec_flush;
  integer      fail_count = 0;
  integer      cmp_count = 0;
  integer      i;
  logic [31:0] rd;
  logic [48:0] rows [0:4];
  localparam [11:0] EB = `SMT_ENTRY_BASE;
  stream_match_table dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sid_valid(i_sid_valid),
    .i_sid(i_sid), .o_lookup_done(o_lookup_done), .o_hit(o_hit), .o_multi_hit(o_multi_hit),
    .o_hit_idx(o_hit_idx), .o_sec_flush(o_sec_flush));
  // ****
  // Tasks
  // ****
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      cmp_count++;
      if (g !== e) begin
        fail_count++;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    integer n;
    begin
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      i_wb_sel <= s;
      n = 0;
      @(posedge i_clk);
      while (o_wb_ack !== 1'b1 && n < 20) begin
        @(posedge i_clk);
        n++;
      end
      chk(n < 20, 1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
    end
  endtask
  task look(input logic [15:0] s);
    begin
      @(posedge i_clk);
      i_sid_valid <= 1'b1;
      i_sid <= s;
      @(posedge i_clk);
      i_sid_valid <= 1'b0;
      @(posedge i_clk);
      chk(o_lookup_done, 1);
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ****
  // Clock, watchdog, tests
  // ****
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Generous: the sequence needs about 120 cycles of the 2500 allowed
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
  initial begin
    {i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, i_sid_valid} = 5'h00;
    i_wb_adr = 12'h000;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0;
    i_sid = 16'h0;
    // Entry word, lookup identifier, expected hit
    rows[0] = {32'h8000_1234, 16'h1234, 1'b1};
    rows[1] = {32'h8000_1234, 16'h1235, 1'b0};
    rows[2] = {32'h0000_1234, 16'h1234, 1'b0};
    rows[3] = {32'h800f_9235, 16'h123a, 1'b1};
    rows[4] = {32'h800f_1235, 16'h124a, 1'b0};
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    chk({o_wb_ack, o_hit, o_lookup_done, o_sec_flush}, 0);
    look(16'h0000);
    chk(o_hit, 0);
    for (i = 0; i < 5; i++) begin
      wb(1'b1, EB, rows[i][48:17], 4'hf);
      wb(1'b0, EB, 32'h0, 4'hf);
      chk(rd, rows[i][48:17] & 32'hffff_7fff);
      look(rows[i][16:1]);
      chk(o_hit, rows[i][0]);
    end
    // Two valid matches: lowest index must win
    wb(1'b1, EB, 32'h0, 4'hf);
    wb(1'b1, EB + 12'h008, 32'h8000_0055, 4'hf);
    wb(1'b1, EB + 12'h014, 32'h8000_0055, 4'hf);
    look(16'h0055);
    chk({o_hit, o_multi_hit, o_hit_idx}, 10'h302);
    wb(1'b0, `SMT_STATUS_OFS, 32'h0, 4'hf);
    chk(rd, 32'hc00f_0002);
    wb(1'b1, EB + 12'h00c, 32'h0, 4'hf);
    wb(1'b1, EB + 12'h00c, 32'hffff_ffff, 4'h1);
    wb(1'b0, EB + 12'h00c, 32'h0, 4'hf);
    chk(rd, 32'h0000_00ff);
    wb(1'b1, EB + 12'h020, 32'h8000_0001, 4'hf);
    wb(1'b0, EB + 12'h020, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b0, 12'h100, 32'h0, 4'hf);
    chk(rd, 32'h0);
    // Wide layout: validity comes from the paired bit only
    wb(1'b1, `SMT_CTRL_OFS, 32'h1, 4'hf);
    wb(1'b1, EB + 12'h004, 32'h0000_8001, 4'hf);
    look(16'h8001);
    chk(o_hit, 0);
    wb(1'b1, `SMT_WIDE_VALID_OFS, 32'h2, 4'hf);
    look(16'h8001);
    chk({o_hit, o_hit_idx}, 9'h101);
    look(16'h0001);
    chk(o_hit, 0);
    wb(1'b1, EB + 12'h004, 32'h8000_8001, 4'hf);
    look(16'h0001);
    chk(o_hit, 1);
    // Any value and lane set must trigger the flush
    wb(1'b1, `SMT_SEC_FLUSH_OFS, 32'h5a5a_0000, 4'h0);
    @(posedge i_clk);
    chk(o_sec_flush, 1);
    wb(1'b0, `SMT_SEC_FLUSH_OFS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    close_out;
  end
endmodule // tb
bind stream_match_table stream_match_table_monitor mon_u (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sid_valid(i_sid_valid),
  .o_lookup_done(o_lookup_done), .o_hit(o_hit), .o_multi_hit(o_multi_hit),
  .o_hit_idx(o_hit_idx), .o_sec_flush(o_sec_flush));
